// ### inc/pcma_params.svh
// Constants for the port configuration mode access block.
// Included by the design files; definitions only.
`ifndef PCMA_PARAMS_SVH
`define PCMA_PARAMS_SVH
`define PCMA_SEL_RESET 5'h1F
`define PCMA_SEL_WRITE_BIT 4
`define PCMA_CFG_RESET 8'hFF
`define PCMA_CODE_CAP_L 4'h0
`define PCMA_CODE_CTRL_A 4'h7
`define PCMA_CODE_CMP 4'h8
`define PCMA_CODE_WKPND 4'h9
`define PCMA_CODE_WKED 4'hA
`define PCMA_CODE_WKEN 4'hB
`define PCMA_CODE_SCHMITT 4'hC
`define PCMA_CODE_LEVEL 4'hD
`define PCMA_CODE_PULLUP 4'hE
`define PCMA_CODE_DIR 4'hF
`define PCMA_CODE_CLR_T1 5'h10
`define PCMA_PORT_A 3'h0
`define PCMA_PORT_B 3'h1
`define PCMA_PORT_C 3'h2
`define PCMA_PORT_E 3'h4
`define PCMA_NUM_PORTS 5
`endif

// ### inc/pcma_pkg.sv
// Types for the port configuration mode access block.
// Uses no numeric constants; those stay in pcma_params.svh.
package pcma_pkg;
  typedef enum logic [1:0] {
    PCMA_OP_NONE,
    PCMA_OP_READ,
    PCMA_OP_WRITE,
    PCMA_OP_SWAP
  } pcma_op_e;
  // One decoded port-control move
  typedef struct packed {
    pcma_op_e op;
    logic [2:0] cls;
  } pcma_dec_s;
endpackage : pcma_pkg

// ### rtl/pcma_decode.sv
// Decoder from selector code and port to the action of a port-control move.
// Combinational; assumes the core presents a stable selector and port.
`timescale 1ns/1ns
`default_nettype none
`include "pcma_params.svh"
module pcma_decode
  import pcma_pkg::*;
(
  input wire logic [4:0] sel,
  input wire logic [2:0] port,
  output pcma_dec_s dec
);
  logic [3:0] code;
  logic wr;
  assign code = sel[3:0];
  assign wr = sel[`PCMA_SEL_WRITE_BIT];
  // Classify: 0 timer, 1 comparator, 2 pending, 3 edge, 4 enable, 5 schmitt, 6 cfg, 7 clear
  always_comb
  begin
    dec.op = PCMA_OP_NONE;
    dec.cls = 3'h0;
    if (code <= `PCMA_CODE_CTRL_A)
    begin
      if (port == `PCMA_PORT_B || port == `PCMA_PORT_C)
      begin
        if (!wr)
        begin
          dec.op = PCMA_OP_READ; // [R10]
        end
        else if (code >= 4'h2)
        begin
          dec.op = PCMA_OP_WRITE; // [R10]
        end
        else if (sel == `PCMA_CODE_CLR_T1 && port == `PCMA_PORT_B)
        begin
          dec.op = PCMA_OP_WRITE; // [R10]
          dec.cls = 3'h7;
        end
      end
    end
    else if (code <= `PCMA_CODE_WKEN)
    begin
      if (port == `PCMA_PORT_B)
      begin
        dec.cls = 3'(code - `PCMA_CODE_CMP + 4'h1);
        dec.op = (code <= `PCMA_CODE_WKPND) ? PCMA_OP_SWAP : PCMA_OP_WRITE; // [R7] [R8]
      end
    end
    else if (code == `PCMA_CODE_SCHMITT)
    begin
      if (port != `PCMA_PORT_A && port <= `PCMA_PORT_E)
      begin
        dec.cls = 3'h5;
        dec.op = wr ? PCMA_OP_WRITE : PCMA_OP_READ; // [R11]
      end
    end
    else if (port <= `PCMA_PORT_E)
    begin
      dec.cls = 3'h6;
      dec.op = wr ? PCMA_OP_WRITE : PCMA_OP_READ; // [R5] [R6] [R11]
    end
  end
endmodule : pcma_decode
`default_nettype wire

// ### rtl/pcma_port_config.sv
// Port configuration mode access: selector register and per-port config registers.
// Assumes the core gives one-cycle strobes for each special move and holds w_in
// steady with them; the timer register files sit outside and answer on timer_rd_data.
// What this block does
// [R1] Selector has no data address; literal move loads low four bits only.
// [R2] Move from working register loads five bits; reverse move returns selector.
// [R3] Software should avoid reserved selector codes.
// [R4] Selector resets to 1Fh, giving direction-register writes.
// [R5] Selector bit 4 low: port move reads target into working register.
// [R6] Selector bit 4 high: port move writes working register into target.
// [R7] Comparator and wakeup-pending on port B always swap with working register.
// [R8] Wakeup edge and enable on port B are always written.
// [R9] Selector holds its value until software writes it again.
// [R10] Timer capture, compare, control reads/writes on ports B, C; 10h clears timer 1.
// [R11] 0Ch Schmitt for B-E; 0Dh-0Fh level, pullup, direction for all ports.
// [R12] Direction bit 1 input, 0 output; resets to 1.
// [R13] Pullup bit 1 disconnects, 0 connects; resets to 1.
// [R14] Level bit 1 TTL, 0 CMOS, with Schmitt off; resets to 1.
// [R15] Software waits over two cycles after level or Schmitt changes.
// [R16] Schmitt bit 0 enables, 1 disables; resets to 1.
// [R17] Wakeup enable bit 0 enables port B pin wakeup; resets to 1.
// [R18] Unmapped code and port combinations change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "pcma_params.svh"
module pcma_port_config
  import pcma_pkg::*;
#(
  parameter int NPORTS = `PCMA_NUM_PORTS
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sel_lit_wr,
  input wire logic [3:0] sel_lit,
  input wire logic sel_w_wr,
  input wire logic port_mv,
  input wire logic [2:0] port_mv_idx,
  input wire logic [7:0] w_in,
  input wire logic [7:0] timer_rd_data,
  input wire logic [7:0] cmp_status,
  input wire logic [7:0] wake_events,
  output logic [4:0] access_selector,
  output logic w_load,
  output logic [7:0] w_out,
  output logic timer_rd,
  output logic timer_wr,
  output logic timer_clear,
  output logic [3:0] timer_code,
  output logic timer_sel_c,
  output logic [7:0] timer_wr_data,
  output logic [NPORTS*8-1:0] pin_direction,
  output logic [NPORTS*8-1:0] pullup_disable,
  output logic [NPORTS*8-1:0] input_threshold_select,
  output logic [NPORTS*8-1:0] schmitt_disable,
  output logic [7:0] comparator_control,
  output logic [7:0] wakeup_pending,
  output logic [7:0] wakeup_edge_select,
  output logic [7:0] wakeup_enable
);
  logic [4:0] sel_reg;
  pcma_dec_s dec;
  logic [7:0] cfg_rd;
  logic [7:0] sw_rd;
  logic [1:0] cfg_kind;

  pcma_decode i_pcma_decode (
    .sel(sel_reg),
    .port(port_mv_idx),
    .dec(dec)
  );

  // Picks the byte of port p out of a packed per-port register
  function automatic logic [7:0] cfg_pick(input logic [NPORTS*8-1:0] v, input logic [2:0] p);
    cfg_pick = v[p*8 +: 8];
  endfunction : cfg_pick

  assign cfg_kind = sel_reg[1:0];

  // Selector register: not in the data map, only special moves reach it
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sel_reg <= `PCMA_SEL_RESET; // [R4]
    end
    else if (sel_w_wr)
    begin
      sel_reg <= w_in[4:0]; // [R2]
    end
    else if (sel_lit_wr)
    begin
      sel_reg <= {sel_reg[4], sel_lit}; // [R1]
    end
  end
  // Holds across port moves; no other path writes it [R9]
  assign access_selector = sel_reg; // [R2]

  // Readback value for the current move
  always_comb
  begin
    cfg_rd = 8'h00;
    case (cfg_kind)
      2'h1: cfg_rd = cfg_pick(input_threshold_select, port_mv_idx);
      2'h2: cfg_rd = cfg_pick(pullup_disable, port_mv_idx);
      2'h3: cfg_rd = cfg_pick(pin_direction, port_mv_idx);
      default: cfg_rd = cfg_pick(schmitt_disable, port_mv_idx);
    endcase
    sw_rd = (dec.cls == 3'h1) ? comparator_control : wakeup_pending;
  end

  // Working register return path
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      w_load <= 1'b0;
      w_out <= 8'h00;
    end
    else
    begin
      w_load <= 1'b0;
      if (port_mv && dec.op == PCMA_OP_READ)
      begin
        w_load <= 1'b1; // [R5]
        w_out <= (dec.cls == 3'h0) ? timer_rd_data : cfg_rd; // [R10] [R11]
      end
      else if (port_mv && dec.op == PCMA_OP_SWAP)
      begin
        w_load <= 1'b1; // [R7]
        w_out <= sw_rd;
      end
      // Unmapped moves leave the working register alone [R18]
    end
  end

  // Timer register strobes toward the timer blocks
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      timer_rd <= 1'b0;
      timer_wr <= 1'b0;
      timer_clear <= 1'b0;
      timer_code <= 4'h0;
      timer_sel_c <= 1'b0;
      timer_wr_data <= 8'h00;
    end
    else
    begin
      timer_rd <= port_mv && dec.op == PCMA_OP_READ && dec.cls == 3'h0; // [R10]
      timer_wr <= port_mv && dec.op == PCMA_OP_WRITE && dec.cls == 3'h0; // [R10]
      timer_clear <= port_mv && dec.op == PCMA_OP_WRITE && dec.cls == 3'h7; // [R10]
      timer_code <= sel_reg[3:0];
      timer_sel_c <= (port_mv_idx == `PCMA_PORT_C);
      timer_wr_data <= w_in;
    end
  end
  // Timer read data must answer combinationally from access_selector and
  // port_mv_idx, since w_out takes it at the same edge as the move.

  // Per-port configuration registers, all reset to FFh
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pin_direction <= {NPORTS{`PCMA_CFG_RESET}}; // [R12]
      pullup_disable <= {NPORTS{`PCMA_CFG_RESET}}; // [R13]
      input_threshold_select <= {NPORTS{`PCMA_CFG_RESET}}; // [R14]
      schmitt_disable <= {NPORTS{`PCMA_CFG_RESET}}; // [R16]
    end
    else if (port_mv && dec.op == PCMA_OP_WRITE)
    begin
      if (dec.cls == 3'h6)
      begin
        case (cfg_kind)
          2'h1: input_threshold_select[port_mv_idx*8 +: 8] <= w_in; // [R14] [R6]
          2'h2: pullup_disable[port_mv_idx*8 +: 8] <= w_in; // [R13] [R6]
          2'h3: pin_direction[port_mv_idx*8 +: 8] <= w_in; // [R12] [R6]
          default: ;
        endcase
      end
      else if (dec.cls == 3'h5)
      begin
        schmitt_disable[port_mv_idx*8 +: 8] <= w_in; // [R16]
      end
    end
  end

  // Port B comparator and wakeup registers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      comparator_control <= `PCMA_CFG_RESET;
      wakeup_pending <= 8'h00;
      wakeup_edge_select <= `PCMA_CFG_RESET;
      wakeup_enable <= `PCMA_CFG_RESET; // [R17]
    end
    else
    begin
      comparator_control[0] <= cmp_status[0];
      if (port_mv && dec.op == PCMA_OP_SWAP && dec.cls == 3'h1)
      begin
        comparator_control[7:1] <= w_in[7:1]; // [R7]
      end
      // New wakeup events win over the swap clear
      if (port_mv && dec.op == PCMA_OP_SWAP && dec.cls == 3'h2)
      begin
        wakeup_pending <= w_in | wake_events; // [R7]
      end
      else
      begin
        wakeup_pending <= wakeup_pending | wake_events;
      end
      if (port_mv && dec.op == PCMA_OP_WRITE && dec.cls == 3'h3)
      begin
        wakeup_edge_select <= w_in; // [R8]
      end
      if (port_mv && dec.op == PCMA_OP_WRITE && dec.cls == 3'h4)
      begin
        wakeup_enable <= w_in; // [R8] [R17]
      end
    end
  end
endmodule : pcma_port_config
`default_nettype wire

// ### verification/pcma_port_config_sva.sv
// Checker for selector loads and port-control moves at the block ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pcma_port_config_sva #(
  parameter int NPORTS = 5
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sel_lit_wr,
  input wire logic [3:0] sel_lit,
  input wire logic sel_w_wr,
  input wire logic port_mv,
  input wire logic [2:0] port_mv_idx,
  input wire logic [7:0] w_in,
  input wire logic [4:0] access_selector,
  input wire logic w_load,
  input wire logic [7:0] w_out,
  input wire logic timer_clear,
  input wire logic [NPORTS*8-1:0] pin_direction,
  input wire logic [7:0] wakeup_pending,
  input wire logic [7:0] wakeup_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // One port-control move with a given selector code and port
  sequence s_mv(logic [4:0] c, logic [2:0] p);
    port_mv && access_selector == c && port_mv_idx == p;
  endsequence
  // Selector loads and holding
  a_sel_reset: assert property (disable iff (1'b0) !reset_n |=> access_selector == 5'h1F)
    else $error("selector not 1Fh after reset");
  a_sel_lit: assert property (sel_lit_wr && !sel_w_wr |=>
    access_selector == {$past(access_selector[4]), $past(sel_lit)})
    else $error("literal selector load wrong");
  a_sel_w: assert property (sel_w_wr |=> access_selector == $past(w_in[4:0]))
    else $error("selector load from w wrong");
  a_sel_hold: assert property (!sel_lit_wr && !sel_w_wr |=> $stable(access_selector))
    else $error("selector changed without a write");
  // Port moves by kind
  a_dir_wr: assert property (s_mv(5'h1F, 3'h1) |=> pin_direction[15:8] == $past(w_in))
    else $error("direction write wrong");
  a_dir_rd: assert property (s_mv(5'h0F, 3'h1) |=> w_load && w_out == pin_direction[15:8])
    else $error("direction read wrong");
  a_pend_swap: assert property (s_mv(5'h19, 3'h1) |=> w_load && w_out == $past(wakeup_pending))
    else $error("pending swap wrong");
  a_wken_wr: assert property (s_mv(5'h0B, 3'h1) |=> !w_load && wakeup_enable == $past(w_in))
    else $error("wake enable write wrong");
  a_unmapped: assert property (s_mv(5'h11, 3'h1) |=> !w_load && $stable(pin_direction))
    else $error("unmapped move had an effect");
  a_t1_clear: assert property (s_mv(5'h10, 3'h1) |=> timer_clear)
    else $error("timer clear missing");
endmodule : pcma_port_config_sva
bind pcma_port_config pcma_port_config_sva #(.NPORTS(NPORTS)) i_pcma_port_config_sva (
  .clk_sys, .reset_n, .sel_lit_wr, .sel_lit, .sel_w_wr, .port_mv, .port_mv_idx, .w_in,
  .access_selector, .w_load, .w_out, .timer_clear, .pin_direction, .wakeup_pending,
  .wakeup_enable);
`default_nettype wire

// ### verification/pcma_timer_model.sv
// Stand-in for the timer register files read through port moves.
// Answers combinationally from selector and port, as the block expects.
`timescale 1ns/1ns
`default_nettype none
module pcma_timer_model
(
  input wire logic [4:0] access_selector,
  input wire logic [2:0] port_mv_idx,
  output logic [7:0] timer_rd_data
);
  // Pattern unique to each code and port, so a wrong select shows
  assign timer_rd_data = {access_selector[3:0], 1'b1, port_mv_idx};
endmodule : pcma_timer_model
`default_nettype wire

// ### verification/test_port_config_mode_access.sv
// Testbench for the port configuration mode access block.
// Drives core moves 1 ns after each rising edge; the checker is bound in.
`timescale 1ns/1ns
`default_nettype none
module test_port_config_mode_access;
  logic clk_sys, reset_n, sel_lit_wr, sel_w_wr, port_mv, w_load;
  logic timer_rd, timer_wr, timer_clear, timer_sel_c;
  logic [2:0] port_mv_idx;
  logic [3:0] sel_lit, timer_code;
  logic [4:0] access_selector;
  logic [7:0] w_in, timer_rd_data, cmp_status, wake_events, w_out, timer_wr_data;
  logic [7:0] comparator_control, wakeup_pending, wakeup_edge_select, wakeup_enable;
  logic [39:0] pin_direction, pullup_disable, input_threshold_select, schmitt_disable;
  int err_count, n_checks;
  pcma_port_config i_pcma_port_config (.clk_sys, .reset_n, .sel_lit_wr, .sel_lit,
    .sel_w_wr, .port_mv, .port_mv_idx, .w_in, .timer_rd_data, .cmp_status, .wake_events,
    .access_selector, .w_load, .w_out, .timer_rd, .timer_wr, .timer_clear, .timer_code,
    .timer_sel_c, .timer_wr_data, .pin_direction, .pullup_disable, .input_threshold_select,
    .schmitt_disable, .comparator_control, .wakeup_pending, .wakeup_edge_select,
    .wakeup_enable);
  pcma_timer_model i_pcma_timer_model (.access_selector, .port_mv_idx, .timer_rd_data);
  // Clock at 25 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sel_w(input logic [4:0] v);
    w_in = {3'h0, v};
    sel_w_wr = 1'b1;
    @(posedge clk_sys);
    #1 sel_w_wr = 1'b0;
  endtask : sel_w
  task automatic sel_l(input logic [3:0] v);
    sel_lit = v;
    sel_lit_wr = 1'b1;
    @(posedge clk_sys);
    #1 sel_lit_wr = 1'b0;
  endtask : sel_l
  task automatic mv(input logic [2:0] p, input logic [7:0] w);
    w_in = w;
    port_mv_idx = p;
    port_mv = 1'b1;
    @(posedge clk_sys);
    #1 port_mv = 1'b0;
  endtask : mv
  // One quiet cycle, so two strobes of one kind never meet in one time step
  task automatic idle;
    @(posedge clk_sys);
    #1;
  endtask : idle
  // Mapped selector codes only, apart from the deliberate refusal
  task automatic op(input logic [4:0] s, input logic [2:0] p, input logic [7:0] w);
    sel_w(s);
    mv(p, w);
  endtask : op
  task automatic t_reset;
    chk(access_selector, 5'h1F);
    chk(pin_direction, {5{8'hFF}});
    chk(pullup_disable, {5{8'hFF}});
    chk(input_threshold_select, {5{8'hFF}});
    chk(schmitt_disable[39:8], {4{8'hFF}});
    chk({wakeup_enable, wakeup_edge_select}, 16'hFFFF);
    chk({comparator_control, wakeup_pending}, 16'hFF00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cfg;
    op(5'h1E, 3'h0, 8'h03);
    chk(pullup_disable[7:0], 8'h03);
    sel_l(4'hD);
    chk(access_selector, 5'h1D);
    mv(3'h4, 8'h5A);
    idle();
    mv(3'h3, 8'hC3);
    chk({access_selector, input_threshold_select[39:24]}, 21'h1D5AC3);
    sel_w(5'h0D);
    mv(3'h4, 8'h00);
    chk({w_load, w_out}, 9'h15A);
    sel_l(4'hF);
    chk(access_selector, 5'h0F);
    op(5'h1C, 3'h2, 8'h11);
    chk(schmitt_disable[23:16], 8'h11);
    op(5'h0C, 3'h2, 8'h00);
    chk({w_load, w_out}, 9'h111);
    op(5'h0C, 3'h0, 8'h00);
    chk({w_load, schmitt_disable[7:0]}, 9'h0FF);
    $display("test config done");
  endtask : t_cfg
  task automatic t_swap;
    wake_events = 8'h81;
    @(posedge clk_sys);
    #1 wake_events = 8'h00;
    op(5'h19, 3'h1, 8'h22);
    chk({w_load, w_out, wakeup_pending}, 17'h18122);
    sel_w(5'h19);
    wake_events = 8'h04;
    mv(3'h1, 8'h00);
    wake_events = 8'h00;
    chk({w_load, w_out, wakeup_pending}, 17'h12204);
    op(5'h08, 3'h1, 8'hC0);
    chk({w_load, w_out, comparator_control}, 17'h1FFC1);
    cmp_status = 8'h00;
    idle();
    chk(comparator_control, 8'hC0);
    op(5'h18, 3'h1, 8'h3F);
    chk({w_load, w_out, comparator_control}, 17'h1C03E);
    cmp_status = 8'h01;
    op(5'h0B, 3'h1, 8'h0F);
    chk({w_load, wakeup_enable}, 9'h00F);
    op(5'h1A, 3'h1, 8'h55);
    chk(wakeup_edge_select, 8'h55);
    $display("test swap done");
  endtask : t_swap
  task automatic t_timer;
    op(5'h10, 3'h1, 8'h00);
    chk(timer_clear, 1'b1);
    op(5'h03, 3'h2, 8'h00);
    chk({timer_rd, timer_code, timer_sel_c, w_load, w_out}, 15'h4F3A);
    op(5'h15, 3'h1, 8'h77);
    chk({timer_wr, timer_code, timer_sel_c, timer_wr_data}, 14'h2A77);
    op(5'h10, 3'h2, 8'h00);
    chk({timer_clear, timer_wr, timer_rd, w_load}, 4'h0);
    $display("test timer done");
  endtask : t_timer
  task automatic t_unmap;
    op(5'h11, 3'h1, 8'h00);
    chk({w_load, timer_clear, timer_wr, timer_rd}, 4'h0);
    op(5'h1F, 3'h5, 8'h00);
    chk(pin_direction, {5{8'hFF}});
    idle();
    mv(3'h1, 8'h3C);
    op(5'h0F, 3'h1, 8'h00);
    chk({w_load, w_out}, 9'h13C);
    $display("test unmapped done");
  endtask : t_unmap
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Main sequence
  initial
  begin
    {reset_n, sel_lit_wr, sel_w_wr, port_mv, sel_lit, port_mv_idx} = '0;
    {w_in, wake_events, cmp_status} = 24'h000001;
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    t_reset();
    t_cfg();
    t_swap();
    t_timer();
    t_unmap();
    stop_test();
  end
  // Watchdog, far beyond the fifty or so cycles the tests need
  initial
  begin
    #16000;
    err_count++;
    stop_test();
  end
endmodule : test_port_config_mode_access
`default_nettype wire
